// *** design/mcd_map.svh ***
// Register offsets, field positions, reset values and timing counts for the calibration datapath
`ifndef MCD_MAP_SVH
`define MCD_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define MCD_ADDR_CTRL        8'h00
`define MCD_ADDR_STATUS      8'h04
`define MCD_ADDR_OV_OVERRIDE 8'h08
`define MCD_ADDR_UV_OVERRIDE 8'h0C
`define MCD_ADDR_CURRENT_OFFSET_VALUE   8'h10
`define MCD_ADDR_CC_SAMPLES  8'h14
`define MCD_ADDR_CURRENT_GAIN_FACTOR     8'h18
`define MCD_ADDR_CAP_GAIN    8'h1C
`define MCD_ADDR_CAL_RESULT  8'h20
`define MCD_ADDR_CURRENT     8'h24
`define MCD_ADDR_OV_ACTIVE   8'h28
`define MCD_ADDR_UV_ACTIVE   8'h2C
`define MCD_ADDR_TOFS_BASE   8'h40
`define MCD_ADDR_TEMP_BASE   8'h80

// ==========================================================================
// Control register fields
`define MCD_CTRL_CFG_UPDATE  0
`define MCD_CTRL_CAL_OV      1
`define MCD_CTRL_CAL_UV      2

// Status register fields
`define MCD_STAT_BUSY        0
`define MCD_STAT_DONE        1
`define MCD_STAT_REFUSED     2

// ==========================================================================
// Reset values
`define MCD_RST_CC_SAMPLES   16'h0001
// 7.4768 / 1 mOhm as single precision
`define MCD_RST_CURRENT_GAIN_FACTOR      32'h40EF41F2
// 298261.6178 as single precision
`define MCD_CAPACITY_CONST   32'h4891A2B4

// ==========================================================================
// Timing: settle time of the comparator after each coefficient step
`define MCD_SETTLE_NS        1000
`define MCD_CLK_NS           100

`endif

// *** design/mcd_pkg.sv ***
// Types for the measurement calibration datapath
`default_nettype none
package mcd_pkg;

    // ======================================================================
    // Threshold search state machine
    typedef enum logic [1:0] {
        MCD_IDLE   = 2'b00,
        MCD_SETTLE = 2'b01,
        MCD_DECIDE = 2'b10,
        MCD_FINISH = 2'b11
    } mcd_state_t;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mcd_req_t;

    // One temperature sample from the sensor front end
    typedef struct packed {
        logic        valid;
        logic [3:0]  sensor;
        logic [15:0] value;
    } mcd_temp_t;

endpackage : mcd_pkg

`default_nettype wire

// *** design/mcd_datapath.sv ***
// Calibration and correction datapath: threshold search, current correction, temperature offsets
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "mcd_map.svh"

module mcd_datapath #(
    parameter int COEF_W    = 8,
    parameter int N_TEMP    = 10,
    parameter int SETTLE_CY = (`MCD_SETTLE_NS + `MCD_CLK_NS - 1) / `MCD_CLK_NS
) (
    input  wire logic                i_clk,
    input  wire logic                i_arst_n,
    input  wire logic [7:0]          i_addr,
    input  wire logic [31:0]         i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    input  wire logic [COEF_W-1:0]   i_ov_factory_trim,
    input  wire logic [COEF_W-1:0]   i_uv_factory_trim,
    input  wire logic                i_cmp_above,
    input  wire logic                i_cc_valid,
    input  wire logic signed [31:0]  i_cc_raw,
    input  wire mcd_pkg::mcd_temp_t  i_temp,
    output logic [31:0]              o_rdata,
    output logic [COEF_W-1:0]        o_cmp_coef,
    output logic [COEF_W-1:0]        o_ov_coef,
    output logic [COEF_W-1:0]        o_uv_coef,
    output logic signed [31:0]       o_current,
    output logic                     o_current_valid,
    output mcd_pkg::mcd_temp_t       o_temp
);

    // ======================================================================
    // Pin-side comparator passes two flip-flops first
    logic cmp_meta;
    logic cmp_sync;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end
        else
        begin
            cmp_meta <= i_cmp_above;
            cmp_sync <= cmp_meta;
        end
    end

    // ======================================================================
    // Configuration registers
    logic                  cfg_update;
    logic [COEF_W-1:0]     ov_override;
    logic [COEF_W-1:0]     uv_override;
    logic signed [31:0]    current_offset_value;
    logic [15:0]           cc_samples;
    logic [31:0]           current_gain_factor;
    logic signed [15:0]    temp_ofs [N_TEMP];
    logic                  cal_done;
    logic                  cal_refused;
    logic [COEF_W-1:0]     cal_result;

    mcd_pkg::mcd_state_t   state;
    logic                  cal_is_ov;
    logic [COEF_W-1:0]     coef;
    logic [COEF_W-1:0]     bit_mask;
    logic [15:0]           settle_cnt;

    wire wr_ctrl = i_wr && (i_addr == `MCD_ADDR_CTRL);
    wire cal_req = wr_ctrl && (i_wdata[`MCD_CTRL_CAL_OV] || i_wdata[`MCD_CTRL_CAL_UV]);
    // Mode must already be set and must not be left by the requesting write
    wire cal_ok  = cal_req && cfg_update && i_wdata[`MCD_CTRL_CFG_UPDATE]
                   && (state == mcd_pkg::MCD_IDLE);
    wire search_end = (state == mcd_pkg::MCD_FINISH);

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cfg_update <= 1'b0;
        else if (wr_ctrl)
            cfg_update <= i_wdata[`MCD_CTRL_CFG_UPDATE];
    end

    // Search result wins over a same-cycle software write of the override
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ov_override <= '0;
            uv_override <= '0;
        end
        else
        begin
            if (search_end && cal_is_ov)
                ov_override <= coef;
            else if (i_wr && i_addr == `MCD_ADDR_OV_OVERRIDE)
                ov_override <= i_wdata[COEF_W-1:0];
            if (search_end && !cal_is_ov)
                uv_override <= coef;
            else if (i_wr && i_addr == `MCD_ADDR_UV_OVERRIDE)
                uv_override <= i_wdata[COEF_W-1:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            current_offset_value  <= '0;
            cc_samples <= `MCD_RST_CC_SAMPLES;
            current_gain_factor    <= `MCD_RST_CURRENT_GAIN_FACTOR;
        end
        else if (i_wr)
        begin
            if (i_addr == `MCD_ADDR_CURRENT_OFFSET_VALUE)
                current_offset_value <= i_wdata;
            if (i_addr == `MCD_ADDR_CC_SAMPLES)
                cc_samples <= i_wdata[15:0];
            if (i_addr == `MCD_ADDR_CURRENT_GAIN_FACTOR)
                current_gain_factor <= i_wdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_TEMP; g++)
        begin : g_tofs
            always_ff @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    temp_ofs[g] <= '0;
                else if (i_wr && i_addr == (`MCD_ADDR_TOFS_BASE + 8'(4 * g)))
                    temp_ofs[g] <= i_wdata[15:0];
            end
        end
    endgenerate

    // ======================================================================
    // Threshold coefficient search: successive approximation, MSB first.
    // The comparator trips when the applied voltage is above the threshold
    // set by the trial coefficient, so a trip keeps the trial bit.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state      <= mcd_pkg::MCD_IDLE;
            cal_is_ov  <= 1'b0;
            coef       <= '0;
            bit_mask   <= '0;
            settle_cnt <= '0;
        end
        else
        begin
            case (state)
                mcd_pkg::MCD_IDLE:
                begin
                    if (cal_ok)
                    begin
                        cal_is_ov  <= i_wdata[`MCD_CTRL_CAL_OV];
                        bit_mask   <= {1'b1, {(COEF_W-1){1'b0}}};
                        coef       <= {1'b1, {(COEF_W-1){1'b0}}};
                        settle_cnt <= 16'(SETTLE_CY);
                        state      <= mcd_pkg::MCD_SETTLE;
                    end
                end
                mcd_pkg::MCD_SETTLE:
                begin
                    settle_cnt <= settle_cnt - 16'h0001;
                    if (settle_cnt == 16'h0001)
                        state <= mcd_pkg::MCD_DECIDE;
                end
                mcd_pkg::MCD_DECIDE:
                begin
                    if (!cmp_sync)
                        coef <= (coef & ~bit_mask) | (bit_mask >> 1);
                    else
                        coef <= coef | (bit_mask >> 1);
                    bit_mask   <= bit_mask >> 1;
                    settle_cnt <= 16'(SETTLE_CY);
                    if (bit_mask[0])
                    begin
                        coef  <= cmp_sync ? coef : (coef & ~bit_mask);
                        state <= mcd_pkg::MCD_FINISH;
                    end
                    else
                        state <= mcd_pkg::MCD_SETTLE;
                end
                mcd_pkg::MCD_FINISH:
                    state <= mcd_pkg::MCD_IDLE;
                default:
                    state <= mcd_pkg::MCD_IDLE;
            endcase
        end
    end

    // Completion and refusal flags: hardware set wins over a software clear
    wire wr_status = i_wr && (i_addr == `MCD_ADDR_STATUS);

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cal_done    <= 1'b0;
            cal_refused <= 1'b0;
            cal_result  <= '0;
        end
        else
        begin
            if (search_end)
            begin
                cal_done   <= 1'b1;
                cal_result <= coef;
            end
            else if (wr_status && i_wdata[`MCD_STAT_DONE])
                cal_done <= 1'b0;
            if (cal_req && !cal_ok)
                cal_refused <= 1'b1;
            else if (wr_status && i_wdata[`MCD_STAT_REFUSED])
                cal_refused <= 1'b0;
        end
    end

    // ======================================================================
    // Comparator threshold drive
    wire [COEF_W-1:0] next_ov = (ov_override != '0) ? ov_override : i_ov_factory_trim;
    wire [COEF_W-1:0] next_uv = (uv_override != '0) ? uv_override : i_uv_factory_trim;
    wire              busy    = (state != mcd_pkg::MCD_IDLE);

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_ov_coef  <= '0;
            o_uv_coef  <= '0;
            o_cmp_coef <= '0;
        end
        else
        begin
            o_ov_coef  <= next_ov;
            o_uv_coef  <= next_uv;
            o_cmp_coef <= busy ? coef : '0;
        end
    end

    // ======================================================================
    // Current correction. Gain is single precision; the product is formed
    // on the mantissa and shifted by the exponent, giving counts times
    // gain in user current units. Rounding toward minus infinity on the shift.
    wire signed [31:0] ofs_per_sample = current_offset_value / $signed({16'h0000, cc_samples});
    wire signed [31:0] cc_corr = i_cc_raw - ofs_per_sample;
    wire        [23:0] mant    = {1'b1, current_gain_factor[22:0]};
    wire signed [56:0] prod    = cc_corr * $signed({1'b0, mant});
    wire        [7:0]  expo    = current_gain_factor[30:23];
    wire signed [56:0] scaled  = (expo >= 8'h96) ? (prod <<< (expo - 8'h96)) : (prod >>> (8'h96 - expo));
    wire signed [31:0] next_current = (current_gain_factor[30:0] == '0) ? 32'sh0 :
                                      (current_gain_factor[31] ? -scaled[31:0] : scaled[31:0]);

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_current       <= '0;
            o_current_valid <= 1'b0;
        end
        else
        begin
            o_current_valid <= i_cc_valid;
            if (i_cc_valid)
                o_current <= next_current;
        end
    end

    // Capacity gain in single precision: multiply mantissas, add exponents
    localparam logic [31:0] CAP_CONST = `MCD_CAPACITY_CONST;
    wire [47:0] cap_prod = {24'h000000, mant} * {24'h000000, 1'b1, CAP_CONST[22:0]};
    wire        cap_norm = cap_prod[47];
    wire [22:0] cap_mant = cap_norm ? cap_prod[46:24] : cap_prod[45:23];
    wire [8:0]  cap_exp  = 9'(expo) + 9'(CAP_CONST[30:23]) - 9'd127 + 9'(cap_norm);
    wire [31:0] cap_gain = (current_gain_factor[30:0] == '0) ? 32'h00000000 :
                           {current_gain_factor[31], cap_exp[7:0], cap_mant};

    // ======================================================================
    // Temperature offset addition
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_temp <= '0;
        else
        begin
            o_temp.valid  <= i_temp.valid && (i_temp.sensor < 4'(N_TEMP));
            o_temp.sensor <= i_temp.sensor;
            o_temp.value  <= (i_temp.sensor < 4'(N_TEMP)) ?
                             i_temp.value + temp_ofs[i_temp.sensor] : i_temp.value;
        end
    end

    // ======================================================================
    // Read port; unmapped addresses read zero
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= '0;
        else if (i_rd)
        begin
            o_rdata <= '0;
            case (i_addr)
                `MCD_ADDR_CTRL:        o_rdata <= {31'h0, cfg_update};
                `MCD_ADDR_STATUS:      o_rdata <= {29'h0, cal_refused, cal_done, busy};
                `MCD_ADDR_OV_OVERRIDE: o_rdata <= 32'(ov_override);
                `MCD_ADDR_UV_OVERRIDE: o_rdata <= 32'(uv_override);
                `MCD_ADDR_CURRENT_OFFSET_VALUE:   o_rdata <= current_offset_value;
                `MCD_ADDR_CC_SAMPLES:  o_rdata <= {16'h0, cc_samples};
                `MCD_ADDR_CURRENT_GAIN_FACTOR:     o_rdata <= current_gain_factor;
                `MCD_ADDR_CAP_GAIN:    o_rdata <= cap_gain;
                `MCD_ADDR_CAL_RESULT:  o_rdata <= 32'(cal_result);
                `MCD_ADDR_CURRENT:     o_rdata <= o_current;
                `MCD_ADDR_OV_ACTIVE:   o_rdata <= 32'(o_ov_coef);
                `MCD_ADDR_UV_ACTIVE:   o_rdata <= 32'(o_uv_coef);
                default:
                begin
                    if (i_addr >= `MCD_ADDR_TOFS_BASE && i_addr < `MCD_ADDR_TOFS_BASE + 8'(4 * N_TEMP))
                        o_rdata <= {{16{temp_ofs[i_addr[5:2]][15]}}, temp_ofs[i_addr[5:2]]};
                end
            endcase
        end
        else
            o_rdata <= '0;
    end

endmodule : mcd_datapath

`default_nettype wire

// *** sim/mcd_datapath_monitor.sv ***
// Port checker for the calibration datapath, bound onto the design
`timescale 1ns/1ns
`default_nettype none
`include "mcd_map.svh"
module mcd_datapath_monitor #(
    parameter int COEF_W = 8
) (
    input wire logic               i_clk,
    input wire logic               i_arst_n,
    input wire logic [7:0]         i_addr,
    input wire logic [31:0]        i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [COEF_W-1:0]  i_ov_factory_trim,
    input wire logic [COEF_W-1:0]  i_uv_factory_trim,
    input wire logic               i_cc_valid,
    input wire mcd_pkg::mcd_temp_t i_temp,
    input wire logic [31:0]        o_rdata,
    input wire logic [COEF_W-1:0]  o_cmp_coef,
    input wire logic [COEF_W-1:0]  o_ov_coef,
    input wire logic [COEF_W-1:0]  o_uv_coef,
    input wire logic               o_current_valid,
    input wire mcd_pkg::mcd_temp_t o_temp
);
    // ======================================================================
    // Helper state
    logic up;
    logic ov_touched;
    logic uv_touched;

    // Factory trim is only guaranteed until software could have set an override
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            up <= 1'b0;
            ov_touched <= 1'b0;
            uv_touched <= 1'b0;
        end
        else
        begin
            up <= 1'b1;
            if (i_wr && (i_addr == `MCD_ADDR_OV_OVERRIDE || (i_addr == `MCD_ADDR_CTRL && i_wdata[1])))
                ov_touched <= 1'b1;
            if (i_wr && (i_addr == `MCD_ADDR_UV_OVERRIDE || (i_addr == `MCD_ADDR_CTRL && i_wdata[2])))
                uv_touched <= 1'b1;
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    AST_CUR_PULSE: assert property (i_cc_valid |=> o_current_valid)
        else $error("corrected current missing after a sample");
    AST_CUR_QUIET: assert property (!i_cc_valid |=> !o_current_valid)
        else $error("corrected current without a sample");
    AST_TEMP_PASS: assert property (i_temp.valid && i_temp.sensor < 4'hA
        |=> o_temp.valid && o_temp.sensor == $past(i_temp.sensor))
        else $error("temperature result lost or misrouted");
    AST_TEMP_DROP: assert property (i_temp.valid && i_temp.sensor >= 4'hA |=> !o_temp.valid)
        else $error("temperature reported for a sensor that does not exist");
    AST_NO_CAL: assert property (i_wr && i_addr == `MCD_ADDR_CTRL && !i_wdata[0] && o_cmp_coef == '0
        |=> o_cmp_coef == '0 [*3])
        else $error("search started outside configuration update");
    AST_CMP_START: assert property ($rose(o_cmp_coef != '0) |-> o_cmp_coef[COEF_W-1])
        else $error("search does not start at the top coefficient bit");
    AST_OV_FACTORY: assert property (up && !ov_touched |-> o_ov_coef == $past(i_ov_factory_trim))
        else $error("overvoltage threshold not factory trim");
    AST_UV_FACTORY: assert property (up && !uv_touched |-> o_uv_coef == $past(i_uv_factory_trim))
        else $error("undervoltage threshold not factory trim");
endmodule : mcd_datapath_monitor

bind mcd_datapath mcd_datapath_monitor #(.COEF_W(COEF_W)) u_monitor (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_ov_factory_trim(i_ov_factory_trim), .i_uv_factory_trim(i_uv_factory_trim),
    .i_cc_valid(i_cc_valid), .i_temp(i_temp), .o_rdata(o_rdata), .o_cmp_coef(o_cmp_coef),
    .o_ov_coef(o_ov_coef), .o_uv_coef(o_uv_coef), .o_current_valid(o_current_valid), .o_temp(o_temp)
);
`default_nettype wire

// *** sim/mcd_cell_model.sv ***
// Model of the top cell reference source and its threshold comparator
`timescale 1ns/1ns
`default_nettype none
module mcd_cell_model #(
    parameter int COEF_W = 8,
    parameter int DLY_NS = 20
) (
    input  wire logic [COEF_W-1:0] i_ref_level,
    input  wire logic [COEF_W-1:0] i_coef,
    output logic                   o_above
);
    // Level is analog and late; the design must synchronise it before use
    assign #(DLY_NS) o_above = (i_ref_level >= i_coef);
endmodule : mcd_cell_model
`default_nettype wire

// *** sim/mcd_datapath_bench.sv ***
// Self-checking bench for the calibration datapath
`timescale 1ns/1ns
`default_nettype none
`include "mcd_map.svh"
module mcd_datapath_bench;
    typedef struct {logic [3:0] sel; logic [31:0] din; logic [31:0] dexp;} mcd_row_t;
    // ======================================================================
    // Signals
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_cc_valid = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic signed [31:0] i_cc_raw = 32'h0;
    mcd_pkg::mcd_temp_t i_temp = '0;
    logic [7:0] ov_trim = 8'hC8;
    logic [7:0] uv_trim = 8'h64;
    logic [7:0] ref_level = 8'h00;
    logic cmp_above;
    logic [31:0] o_rdata;
    logic [7:0] cmp_coef, ov_coef, uv_coef;
    logic signed [31:0] current;
    logic cur_valid;
    mcd_pkg::mcd_temp_t temp_out;
    logic [31:0] d;
    int num_errors = 0;
    int comparisons = 0;
    // Sel F is a current sample, otherwise a temperature sensor number
    mcd_row_t rows [7] = '{
        '{4'hF, 32'h00000401, 32'h000007D0}, '{4'hF, 32'hFFFFFC31, 32'hFFFFF830},
        '{4'hF, 32'h00000019, 32'h00000000}, '{4'h0, 32'h00000B9A, 32'h00000B90},
        '{4'h0, 32'h00000003, 32'h0000FFF9}, '{4'h4, 32'h00000005, 32'h00000007},
        '{4'h9, 32'h00000BB8, 32'h00000BC9}};

    always #50 i_clk = ~i_clk;

    mcd_cell_model #(.COEF_W(8)) u_cell (.i_ref_level(ref_level), .i_coef(cmp_coef), .o_above(cmp_above));

    // Settle must outlast the output register, model delay and both sync stages: 3 needed, 4 kept
    mcd_datapath #(.COEF_W(8), .N_TEMP(10), .SETTLE_CY(4)) dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ov_factory_trim(ov_trim),
        .i_uv_factory_trim(uv_trim), .i_cmp_above(cmp_above), .i_cc_valid(i_cc_valid),
        .i_cc_raw(i_cc_raw), .i_temp(i_temp), .o_rdata(o_rdata), .o_cmp_coef(cmp_coef),
        .o_ov_coef(ov_coef), .o_uv_coef(uv_coef), .o_current(current),
        .o_current_valid(cur_valid), .o_temp(temp_out));

    // ======================================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rdc

    task automatic smp(input mcd_row_t r);
        @(posedge i_clk);
        if (r.sel == 4'hF)
        begin
            i_cc_valid <= 1'b1;
            i_cc_raw <= r.din;
        end
        else
            i_temp <= '{1'b1, r.sel, r.din[15:0]};
        @(posedge i_clk);
        i_cc_valid <= 1'b0;
        i_temp.valid <= 1'b0;
        #1;
    endtask : smp

    task automatic do_cal(input logic [31:0] ctl, input logic [7:0] refv, input logic [7:0] oa);
        ref_level = refv;
        wr(`MCD_ADDR_CTRL, 32'h1);
        wr(`MCD_ADDR_CTRL, ctl);
        d = 32'h0;
        for (int i = 0; i < 300 && d[1:0] !== 2'b10; i++)
            rd(`MCD_ADDR_STATUS, d);
        chk(d, 32'h2);
        rdc(`MCD_ADDR_CAL_RESULT, {24'h0, refv});
        rdc(oa, {24'h0, refv});
        wr(`MCD_ADDR_STATUS, 32'h2);
        rdc(`MCD_ADDR_STATUS, 32'h0);
    endtask : do_cal

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // ======================================================================
    // Sequence
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rdc(`MCD_ADDR_CC_SAMPLES, 32'(`MCD_RST_CC_SAMPLES));
        rdc(`MCD_ADDR_CURRENT_GAIN_FACTOR, `MCD_RST_CURRENT_GAIN_FACTOR);
        rdc(`MCD_ADDR_OV_OVERRIDE, 32'h0);
        rdc(8'h3C, 32'h0);
        chk({24'h0, ov_coef}, 32'hC8);
        chk({24'h0, uv_coef}, 32'h64);
        $display("reset test done");
        wr(`MCD_ADDR_CURRENT_OFFSET_VALUE, 32'h64);
        wr(`MCD_ADDR_CC_SAMPLES, 32'h4);
        // Gain 2.0 stands for a 3.7384 mOhm sense resistor
        wr(`MCD_ADDR_CURRENT_GAIN_FACTOR, 32'h40000000);
        // Offset of sensor n is 3n - 10 tenths of a kelvin
        for (int n = 0; n < 10; n++)
            wr(`MCD_ADDR_TOFS_BASE + 8'(4 * n), 32'(16'hFFF6 + 16'(3 * n)));
        wr(`MCD_ADDR_CAP_GAIN, 32'h0);
        rdc(`MCD_ADDR_CAP_GAIN, `MCD_CAPACITY_CONST + 32'h00800000);
        foreach (rows[k])
        begin
            smp(rows[k]);
            if (rows[k].sel == 4'hF)
            begin
                chk({31'h0, cur_valid}, 32'h1);
                chk(current, rows[k].dexp);
            end
            else
                chk({11'h0, temp_out}, {11'h0, 1'b1, rows[k].sel, rows[k].dexp[15:0]});
        end
        rdc(`MCD_ADDR_CURRENT, 32'h0);
        rdc(`MCD_ADDR_TOFS_BASE, 32'hFFFFFFF6);
        rdc(`MCD_ADDR_TOFS_BASE + 8'h24, 32'h00000011);
        $display("table test done");
        smp('{4'hA, 32'h00001234, 32'h0});
        chk({31'h0, temp_out.valid}, 32'h0);
        wr(`MCD_ADDR_CTRL, 32'h2);
        repeat (2) @(posedge i_clk);
        rdc(`MCD_ADDR_STATUS, 32'h4);
        wr(`MCD_ADDR_STATUS, 32'h4);
        rdc(`MCD_ADDR_STATUS, 32'h0);
        chk({24'h0, ov_coef}, 32'hC8);
        $display("refusal test done");
        do_cal(32'h3, 8'h5A, `MCD_ADDR_OV_OVERRIDE);
        chk({24'h0, ov_coef}, 32'h5A);
        rdc(`MCD_ADDR_OV_ACTIVE, 32'h5A);
        do_cal(32'h5, 8'h21, `MCD_ADDR_UV_OVERRIDE);
        chk({24'h0, uv_coef}, 32'h21);
        wr(`MCD_ADDR_UV_OVERRIDE, 32'h0);
        repeat (2) @(posedge i_clk);
        chk({24'h0, uv_coef}, 32'h64);
        rdc(`MCD_ADDR_UV_ACTIVE, 32'h64);
        chk({24'h0, ov_coef}, 32'h5A);
        $display("calibration test done");
        stop_test();
    end

    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
endmodule : mcd_datapath_bench
`default_nettype wire
